/* File: shared/bjr_pkg.sv */
// constants, encodings and types of the branch and jump resolution unit
// assumes a 64-bit datapath and 32-bit instruction words in the base encoding
// Behaviour
// - one delay slot after every control transfer
// - linking transfers other than indirect link write the link register
// - region target: pc high bits, field shifted
// - indirect target taken from operand one
// - indirect link writes slot-following address
// - region link mode swap inverts mode bit
// - branch target: slot pc plus offset
// - likely not taken nullifies slot instruction
// - target fetch issued in operate stage
// - compare and target computed before operate stage
// - equal and unequal compare both operands
// - signed zero compares on operand one
// - sign-test links write regardless of outcome
// - coprocessor branches follow condition signal
// - likely forms share conditions, drop slot
`default_nettype none
package bjr_pkg;

  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int unsigned XLEN      = 64;
  localparam int unsigned INSTR_W   = 32;
  localparam int unsigned IDX_W     = 5;
  localparam int unsigned OPC_LO    = 26;
  localparam int unsigned OPND1_LO  = 21;
  localparam int unsigned OPND2_LO  = 16;
  localparam int unsigned DEST_LO   = 11;
  localparam int unsigned OFFSET_W  = 16;
  localparam int unsigned REGION_W  = 26;
  localparam int unsigned PC_HIGH_W = 4;
  localparam int unsigned DELAY_SLOTS = 1;

  localparam logic [IDX_W-1:0] LINK_REGISTER = 5'h1f;
  localparam logic [XLEN-1:0]  INSTR_BYTES   = 64'h0000_0000_0000_0004;
  localparam logic [XLEN-1:0]  LINK_STEP     = 64'h0000_0000_0000_0008;

  // ---------------------------------------------------------------
  // primary opcodes
  // ---------------------------------------------------------------
  localparam logic [5:0] OPC_SPECIAL     = 6'h00;
  localparam logic [5:0] OPC_IMM_GROUP   = 6'h01;
  localparam logic [5:0] OPC_GOTO        = 6'h02;
  localparam logic [5:0] OPC_GOTO_LINK   = 6'h03;
  localparam logic [5:0] OPC_EQUAL       = 6'h04;
  localparam logic [5:0] OPC_UNEQUAL     = 6'h05;
  localparam logic [5:0] OPC_NONPOS      = 6'h06;
  localparam logic [5:0] OPC_POSITIVE    = 6'h07;
  localparam logic [5:0] OPC_COP0        = 6'h10;
  localparam logic [5:0] OPC_L_EQUAL     = 6'h14;
  localparam logic [5:0] OPC_L_UNEQUAL   = 6'h15;
  localparam logic [5:0] OPC_L_NONPOS    = 6'h16;
  localparam logic [5:0] OPC_L_POSITIVE  = 6'h17;
  localparam logic [5:0] OPC_MODE_SWAP   = 6'h1d;

  // special function codes and sub-codes
  localparam logic [5:0] FN_INDIRECT      = 6'h08;
  localparam logic [5:0] FN_INDIRECT_LINK = 6'h09;
  localparam logic [4:0] COP_BRANCH_SUB   = 5'h08;
  localparam logic [1:0] SUB_LIKELY_BIT   = 2'h1;
  localparam logic [4:0] SUB_LINK_BIT     = 5'h10;

  // condition evaluated on the operands
  typedef enum logic [3:0] {
    BJR_ALWAYS = 4'h0,
    BJR_EQ     = 4'h1,
    BJR_NE     = 4'h2,
    BJR_LEZ    = 4'h3,
    BJR_GTZ    = 4'h4,
    BJR_LTZ    = 4'h5,
    BJR_GEZ    = 4'h6,
    BJR_COPT   = 4'h7,
    BJR_COPF   = 4'h8
  } bjr_cond_e;

  // resolution state: one-hot
  typedef enum logic [1:0] {
    BJR_OPEN = 2'b01,
    BJR_SLOT = 2'b10
  } bjr_state_e;

endpackage
`default_nettype wire

/* File: rtl/bjr_cond_eval.sv */
// branch condition evaluator: equality, signed zero tests, coprocessor flag
// assumes operands are already read from the register file this cycle
`timescale 1ns/100ps
`default_nettype none
module bjr_cond_eval (
  input  wire logic              cond_kind_i_unused_guard,
  input  wire bjr_pkg::bjr_cond_e cond_kind,
  input  wire logic [63:0]       operand_one,
  input  wire logic [63:0]       operand_two,
  input  wire logic              cop_flag,
  output logic                   cond_true
);

  // ---------------------------------------------------------------
  // comparison
  // ---------------------------------------------------------------
  logic is_zero;
  logic is_neg;
  logic is_same;

  // sign bit and zero test together decide the signed relation against zero
  assign is_zero = (operand_one == '0);
  assign is_neg  = operand_one[63];
  assign is_same = (operand_one == operand_two);

  // select the relation for the decoded branch
  always_comb begin
    case (cond_kind)
      bjr_pkg::BJR_ALWAYS: cond_true = 1'b1;
      bjr_pkg::BJR_EQ:     cond_true = is_same;
      bjr_pkg::BJR_NE:     cond_true = !is_same;
      bjr_pkg::BJR_LEZ:    cond_true = is_neg || is_zero;
      bjr_pkg::BJR_GTZ:    cond_true = !is_neg && !is_zero;
      bjr_pkg::BJR_LTZ:    cond_true = is_neg;
      bjr_pkg::BJR_GEZ:    cond_true = !is_neg;
      bjr_pkg::BJR_COPT:   cond_true = cop_flag;
      bjr_pkg::BJR_COPF:   cond_true = !cop_flag;
      default:             cond_true = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

/* File: rtl/bjr_unit.sv */
// branch and jump resolution: decode, condition, target, link and slot handling
// assumes the fetch stage follows redirect_q in the cycle after the branch resolves
// and that the register file writes link_data_q when link_we_q is high
`timescale 1ns/100ps
`default_nettype none
module bjr_unit (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [63:0] instr_pc,
  input  wire logic [63:0] operand_one,
  input  wire logic [63:0] operand_two,
  input  wire logic        cop_flag,
  input  wire logic        mode64,
  output logic             redirect_q,
  output logic [63:0]      redirect_target_q,
  output logic             nullify_slot_q,
  output logic             link_we_q,
  output logic [4:0]       link_idx_q,
  output logic [63:0]      link_data_q,
  output logic             isa_mode_q
);

  // ---------------------------------------------------------------
  // decode in the operand read stage
  // ---------------------------------------------------------------
  logic [5:0]          opc;
  logic [4:0]          sub_code;
  logic [4:0]          opnd1_field;
  logic                is_ctl;
  logic                is_region;
  logic                is_indirect;
  logic                is_swap;
  logic                is_likely;
  logic                has_link;
  logic                dest_link;
  bjr_pkg::bjr_cond_e  kind;

  assign opc         = instr_word[31:bjr_pkg::OPC_LO];
  assign sub_code    = instr_word[bjr_pkg::OPND2_LO +: 5];
  assign opnd1_field = instr_word[bjr_pkg::OPND1_LO +: 5];

  // opcode classes in the base encoding
  always_comb begin
    is_ctl      = 1'b1;
    is_region   = 1'b0;
    is_indirect = 1'b0;
    is_swap     = 1'b0;
    is_likely   = 1'b0;
    has_link    = 1'b0;
    dest_link   = 1'b0;
    kind        = bjr_pkg::BJR_ALWAYS;
    case (opc)
      bjr_pkg::OPC_GOTO:      is_region = 1'b1;
      bjr_pkg::OPC_GOTO_LINK: begin
        is_region = 1'b1;
        has_link  = 1'b1;
      end
      bjr_pkg::OPC_MODE_SWAP: begin
        is_region = 1'b1;
        has_link  = 1'b1;
        is_swap   = 1'b1;
      end
      bjr_pkg::OPC_SPECIAL: begin
        is_indirect = 1'b1;
        is_ctl      = (instr_word[5:0] == bjr_pkg::FN_INDIRECT) ||
                      (instr_word[5:0] == bjr_pkg::FN_INDIRECT_LINK);
        has_link    = (instr_word[5:0] == bjr_pkg::FN_INDIRECT_LINK);
        dest_link   = has_link;
      end
      bjr_pkg::OPC_EQUAL,    bjr_pkg::OPC_L_EQUAL:    kind = bjr_pkg::BJR_EQ;
      bjr_pkg::OPC_UNEQUAL,  bjr_pkg::OPC_L_UNEQUAL:  kind = bjr_pkg::BJR_NE;
      bjr_pkg::OPC_NONPOS,   bjr_pkg::OPC_L_NONPOS:   kind = bjr_pkg::BJR_LEZ;
      bjr_pkg::OPC_POSITIVE, bjr_pkg::OPC_L_POSITIVE: kind = bjr_pkg::BJR_GTZ;
      bjr_pkg::OPC_IMM_GROUP: begin
        // sub-codes 0..3 plain and likely, 16..19 the linking forms
        is_ctl    = (sub_code[3:2] == 2'b00);
        kind      = sub_code[0] ? bjr_pkg::BJR_GEZ : bjr_pkg::BJR_LTZ;
        is_likely = sub_code[1];
        has_link  = (sub_code & bjr_pkg::SUB_LINK_BIT) != 5'h00;
      end
      bjr_pkg::OPC_COP0: begin
        // only the four condition sub-codes branch; the rest are ignored
        is_ctl    = (opnd1_field == bjr_pkg::COP_BRANCH_SUB) && (sub_code[4:2] == 3'h0);
        kind      = sub_code[0] ? bjr_pkg::BJR_COPT : bjr_pkg::BJR_COPF;
        is_likely = sub_code[1];
      end
      default: is_ctl = 1'b0;
    endcase
    if (opc[5:2] == bjr_pkg::OPC_L_EQUAL[5:2]) begin
      is_likely = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // condition and targets, ready before the operate stage
  // ---------------------------------------------------------------
  logic        cond_true;
  logic [63:0] slot_pc;
  logic [63:0] region_tgt;
  logic [63:0] indirect_tgt;
  logic [63:0] branch_tgt;
  logic [63:0] offset_ext;

  bjr_cond_eval u_cond (
    .cond_kind_i_unused_guard (1'b0),
    .cond_kind                (kind),
    .operand_one              (operand_one),
    .operand_two              (operand_two),
    .cop_flag                 (cop_flag),
    .cond_true                (cond_true)
  );

  // the slot address feeds the region and branch targets, so it is added once
  assign slot_pc      = instr_pc + bjr_pkg::INSTR_BYTES;
  assign region_tgt   = {slot_pc[63:28], instr_word[25:0], 2'b00};
  // in 32-bit mode only the low word counts, sign-extended
  assign indirect_tgt = mode64 ? operand_one :
                        {{32{operand_one[31]}}, operand_one[31:0]};
  assign offset_ext   = {{46{instr_word[15]}}, instr_word[15:0], 2'b00};
  assign branch_tgt   = slot_pc + offset_ext;

  // ---------------------------------------------------------------
  // slot tracking state
  // ---------------------------------------------------------------
  bjr_pkg::bjr_state_e state_q;
  bjr_pkg::bjr_state_e state_d;
  logic                fire;

  // a transfer sitting in a delay slot is passed through unresolved
  assign fire = instr_valid && is_ctl && (state_q == bjr_pkg::BJR_OPEN);

  // next slot state
  always_comb begin
    state_d = state_q;
    case (state_q)
      bjr_pkg::BJR_OPEN: if (fire) begin
        state_d = bjr_pkg::BJR_SLOT;
      end
      bjr_pkg::BJR_SLOT: if (instr_valid) begin
        state_d = bjr_pkg::BJR_OPEN;
      end
      default: state_d = bjr_pkg::BJR_OPEN;
    endcase
  end

  // register the slot state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= bjr_pkg::BJR_OPEN;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // resolution outputs, presented in the operate stage
  // ---------------------------------------------------------------
  logic        redirect_d;
  logic [63:0] redirect_target_d;
  logic        nullify_slot_d;
  logic        link_we_d;
  logic [4:0]  link_idx_d;
  logic [63:0] link_data_d;
  logic        isa_mode_d;

  // next values; the slot always runs unless a likely branch falls through
  always_comb begin
    redirect_d        = fire && cond_true;
    redirect_target_d = is_region   ? region_tgt :
                        is_indirect ? indirect_tgt : branch_tgt;
    nullify_slot_d    = fire && is_likely && !cond_true;
    link_we_d         = fire && has_link;
    link_idx_d        = dest_link ? instr_word[bjr_pkg::DEST_LO +: 5] :
                                    bjr_pkg::LINK_REGISTER;
    link_data_d       = instr_pc + bjr_pkg::LINK_STEP;
    isa_mode_d        = isa_mode_q ^ (fire && is_swap);
  end

  // register the outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      redirect_q        <= 1'b0;
      redirect_target_q <= 64'h0000_0000_0000_0000;
      nullify_slot_q    <= 1'b0;
      link_we_q         <= 1'b0;
      link_idx_q        <= 5'h00;
      link_data_q       <= 64'h0000_0000_0000_0000;
      isa_mode_q        <= 1'b0;
    end else begin
      redirect_q        <= redirect_d;
      redirect_target_q <= redirect_target_d;
      nullify_slot_q    <= nullify_slot_d;
      link_we_q         <= link_we_d;
      link_idx_q        <= link_idx_d;
      link_data_q       <= link_data_d;
      isa_mode_q        <= isa_mode_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_fire_region;
    fire && is_region;
  endsequence

  sequence s_redirect_region;
    redirect_q ##0 (redirect_target_q[27:0] == {$past(instr_word[25:0]), 2'b00});
  endsequence

  // the delay slot instruction itself, which must pass through unresolved
  sequence s_slot_taken;
    instr_valid && (state_q == bjr_pkg::BJR_SLOT);
  endsequence

  a_slot_follows: assert property (fire |=> state_q == bjr_pkg::BJR_SLOT)
    else $error("delay slot not tracked after transfer");
  a_slot_closes: assert property (s_slot_taken |=> state_q == bjr_pkg::BJR_OPEN)
    else $error("delay slot not closed");
  a_slot_quiet: assert property (s_slot_taken |=> !redirect_q &&
    !nullify_slot_q && !link_we_q)
    else $error("delay slot instruction resolved");
  a_link_fixed: assert property (fire && has_link && !dest_link |=>
    link_we_q && link_idx_q == bjr_pkg::LINK_REGISTER)
    else $error("link not written to link register");
  a_region_target: assert property (s_fire_region |=> s_redirect_region)
    else $error("region target wrong");
  a_indirect_target: assert property (fire && is_indirect && mode64 |=>
    redirect_q && redirect_target_q == $past(operand_one))
    else $error("indirect target wrong");
  a_indirect_link: assert property (fire && dest_link |=> link_we_q &&
    link_idx_q == $past(instr_word[15:11]) && link_data_q == $past(instr_pc) + 64'h8)
    else $error("indirect link wrong");
  a_mode_swap: assert property (fire && is_swap |=>
    isa_mode_q != $past(isa_mode_q))
    else $error("mode bit not inverted");
  a_branch_target: assert property (fire && !is_region && !is_indirect &&
    cond_true |=> redirect_target_q == $past(branch_tgt) &&
    redirect_target_q - $past(instr_pc) - 64'h4 == $past(offset_ext))
    else $error("branch target wrong");
  a_likely_drop: assert property (fire && is_likely && !cond_true |=>
    nullify_slot_q && !redirect_q)
    else $error("likely fall-through did not nullify");
  a_plain_keep: assert property (fire && !is_likely |=> !nullify_slot_q)
    else $error("plain branch nullified slot");
  a_operate_fetch: assert property (redirect_q |-> $past(fire) &&
    $past(state_q) == bjr_pkg::BJR_OPEN)
    else $error("redirect without resolved transfer");
  a_equal_cmp: assert property (fire && kind == bjr_pkg::BJR_EQ |=>
    redirect_q == ($past(operand_one) == $past(operand_two)))
    else $error("equal compare wrong");
  a_zero_cmp: assert property (fire && kind == bjr_pkg::BJR_LEZ |=>
    redirect_q == ($signed($past(operand_one)) <= 0))
    else $error("nonpositive compare wrong");
  a_sign_link: assert property (fire && opc == bjr_pkg::OPC_IMM_GROUP &&
    has_link |=> link_we_q && link_data_q == $past(instr_pc) + 64'h8)
    else $error("sign-test link missing");
  a_cop_cond: assert property (fire && kind == bjr_pkg::BJR_COPT |=>
    redirect_q == $past(cop_flag))
    else $error("coprocessor branch wrong");

endmodule
`default_nettype wire

/* File: dv/bjr_regfile_model.sv */
// register file model on the far side of the resolution unit
// assumes link writes come as one-cycle strobes clocked by sys_clk
`timescale 1ns/100ps
`default_nettype none
module bjr_regfile_model (
  input  wire logic        sys_clk,
  input  wire logic        link_we,
  input  wire logic [4:0]  link_idx,
  input  wire logic [63:0] link_data,
  input  wire logic [4:0]  rd_idx,
  output logic      [63:0] rd_data
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [63:0] regs_q [32];

  // register zero is hardwired, so a link aimed at it is dropped here
  always_ff @(posedge sys_clk) begin
    if (link_we && (link_idx != 5'h00)) begin
      regs_q[link_idx] <= link_data;
    end
  end

  // reads are combinational, as the operand read stage sees them
  assign rd_data = (rd_idx == 5'h00) ? 64'h0 : regs_q[rd_idx];
endmodule
`default_nettype wire

/* File: dv/bjr_unit_bench.sv */
// self-checking bench for the branch and jump resolution unit
// assumes inputs change at the falling edge and outputs settle one edge later
`timescale 1ns/100ps
`default_nettype none
module bjr_unit_bench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        sys_clk, resetn, instr_valid, cop_flag, mode64;
  logic [31:0] instr_word;
  logic [63:0] instr_pc, operand_one, operand_two, redirect_target_q, link_data_q, rd_data;
  logic        redirect_q, nullify_slot_q, link_we_q, isa_mode_q;
  logic [4:0]  link_idx_q, rd_idx;
  int          fail_count, checks_done;

  bjr_unit bjr_unit_inst (.sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc), .operand_one(operand_one),
    .operand_two(operand_two), .cop_flag(cop_flag), .mode64(mode64),
    .redirect_q(redirect_q), .redirect_target_q(redirect_target_q),
    .nullify_slot_q(nullify_slot_q), .link_we_q(link_we_q), .link_idx_q(link_idx_q),
    .link_data_q(link_data_q), .isa_mode_q(isa_mode_q));

  bjr_regfile_model bjr_regfile_model_inst (.sys_clk(sys_clk), .link_we(link_we_q),
    .link_idx(link_idx_q), .link_data(link_data_q), .rd_idx(rd_idx), .rd_data(rd_data));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [63:0] btgt(input logic [63:0] pc, input logic [15:0] off);
    return pc + 64'h4 + {{46{off[15]}}, off, 2'b00};
  endfunction

  // region target keeps the high bits of the slot address, not the jump's own
  function automatic logic [63:0] rtgt(input logic [63:0] pc, input logic [25:0] f);
    logic [63:0] p4;
    p4 = pc + 64'h4;
    return {p4[63:28], f, 2'b00};
  endfunction

  // present one instruction at a falling edge; outputs are seen one edge later
  task automatic send(input logic [31:0] w, input logic [63:0] pc, a, b, input logic c);
    instr_valid = 1'b1;
    instr_word = w;
    instr_pc = pc;
    operand_one = a;
    operand_two = b;
    cop_flag = c;
    @(negedge sys_clk);
  endtask

  // a transfer, its expected answer, then an ordinary slot that must stay quiet
  task automatic xfer(input logic [31:0] w, input logic [63:0] pc, a, b, input logic c,
                      input logic red, input logic [63:0] tgt, input logic nul, lwe,
                      input logic [4:0] idx);
    send(w, pc, a, b, c);
    cmp({63'h0, redirect_q}, {63'h0, red}, "redirect");
    if (red) cmp(redirect_target_q, tgt, "target");
    cmp({63'h0, nullify_slot_q}, {63'h0, nul}, "nullify");
    cmp({63'h0, link_we_q}, {63'h0, lwe}, "link strobe");
    if (lwe) begin
      cmp({59'h0, link_idx_q}, {59'h0, idx}, "link index");
      cmp(link_data_q, pc + 64'h8, "link data");
      rd_idx = idx;
    end
    send(32'h0000_0000, pc + 64'h4, a, b, c);
    cmp({61'h0, redirect_q, nullify_slot_q, link_we_q}, 64'h0, "slot quiet");
    if (lwe) cmp(rd_data, (idx == 5'h00) ? 64'h0 : pc + 64'h8, "register file");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_two_operand;
    logic [63:0] a [3];
    logic [63:0] b [3];
    logic [5:0]  op;
    logic [15:0] off;
    logic        tk;
    a = '{64'h0, 64'h8000_0000_0000_0000, 64'h5};
    b = '{64'h0, 64'h1, 64'h7};
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 3; k++) begin
        op = 6'h04 + i[5:0] + ((i >= 4) ? 6'h0c : 6'h00);
        off = (k == 2) ? 16'h7fff : 16'hfffe;
        case (op[1:0])
          2'h0: tk = (a[k] == b[k]);
          2'h1: tk = (a[k] != b[k]);
          2'h2: tk = ($signed(a[k]) <= 0);
          default: tk = ($signed(a[k]) > 0);
        endcase
        xfer({op, 10'h0, off}, 64'h8000_1000 + k * 256, a[k], b[k], 1'b0, tk,
             btgt(64'h8000_1000 + k * 256, off), op[4] & !tk, 1'b0, 5'h0);
      end
    end
    $display("test two_operand done");
  endtask

  task automatic t_imm_group;
    logic [63:0] a [3];
    logic [4:0]  sub;
    logic        tk;
    a = '{64'hffff_ffff_ffff_fff0, 64'h0, 64'h3};
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 3; k++) begin
        sub = {i[2], 2'b00, i[1:0]};
        tk = sub[0] ? !a[k][63] : a[k][63];
        xfer({6'h01, 5'h02, sub, 16'h0010}, 64'h40_0000, a[k], 64'h0, 1'b0, tk,
             btgt(64'h40_0000, 16'h0010), sub[1] & !tk, sub[4], 5'h1f);
      end
    end
    $display("test imm_group done");
  endtask

  task automatic t_cop;
    logic tk;
    for (int i = 0; i < 8; i++) begin
      tk = i[0] ? i[2] : !i[2];
      xfer({6'h10, 5'h08, 3'h0, i[1:0], 16'h8000}, 64'h2_0000, 64'h0, 64'h0, i[2], tk,
           btgt(64'h2_0000, 16'h8000), i[1] & !tk, 1'b0, 5'h0);
    end
    $display("test cop done");
  endtask

  task automatic t_jumps;
    logic [63:0] pc;
    logic        m;
    pc = 64'h1fff_fffc;
    xfer({6'h02, 26'h2ab_cdef}, pc, 64'h0, 64'h0, 1'b0, 1'b1, rtgt(pc, 26'h2ab_cdef),
         1'b0, 1'b0, 5'h0);
    xfer({6'h03, 26'h155_0001}, pc, 64'h0, 64'h0, 1'b0, 1'b1, rtgt(pc, 26'h155_0001),
         1'b0, 1'b1, 5'h1f);
    for (int i = 0; i < 2; i++) begin
      m = isa_mode_q;
      xfer({6'h1d, 26'h000_0040}, pc, 64'h0, 64'h0, 1'b0, 1'b1, rtgt(pc, 26'h000_0040),
           1'b0, 1'b1, 5'h1f);
      cmp({63'h0, isa_mode_q}, {63'h0, !m}, "mode bit");
    end
    xfer({6'h00, 5'h04, 15'h0, 6'h08}, 64'h100, 64'h1234_5678_9abc_def0, 64'h0, 1'b0,
         1'b1, 64'h1234_5678_9abc_def0, 1'b0, 1'b0, 5'h0);
    mode64 = 1'b0;
    xfer({6'h00, 5'h04, 15'h0, 6'h08}, 64'h100, 64'h5555_0000_8000_0010, 64'h0, 1'b0,
         1'b1, 64'hffff_ffff_8000_0010, 1'b0, 1'b0, 5'h0);
    mode64 = 1'b1;
    xfer({6'h00, 5'h04, 5'h00, 5'h07, 5'h00, 6'h09}, 64'h200, 64'h8, 64'h0, 1'b0, 1'b1,
         64'h8, 1'b0, 1'b1, 5'h07);
    xfer({6'h00, 5'h04, 5'h00, 5'h00, 5'h00, 6'h09}, 64'h300, 64'hc, 64'h0, 1'b0, 1'b1,
         64'hc, 1'b0, 1'b1, 5'h00);
    $display("test jumps done");
  endtask

  // a transfer sitting in a delay slot passes as an ordinary instruction
  task automatic t_slot;
    send({6'h04, 10'h0, 16'h0004}, 64'h500, 64'h1, 64'h1, 1'b0);
    cmp({63'h0, redirect_q}, 64'h1, "first redirect");
    send({6'h04, 10'h0, 16'h0004}, 64'h504, 64'h1, 64'h1, 1'b0);
    cmp({61'h0, redirect_q, nullify_slot_q, link_we_q}, 64'h0, "slot transfer");
    xfer({6'h00, 10'h0, 10'h0, 6'h20}, 64'h508, 64'h0, 64'h0, 1'b0, 1'b0, 64'h0, 1'b0,
         1'b0, 5'h0);
    $display("test slot done");
  endtask

  // ---------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if ((fail_count == 0) && (checks_done > 0)) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    fail_count = 0;
    checks_done = 0;
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr_word = 32'h0;
    instr_pc = 64'h0;
    operand_one = 64'h0;
    operand_two = 64'h0;
    cop_flag = 1'b0;
    mode64 = 1'b1;
    rd_idx = 5'h0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    t_two_operand();
    t_imm_group();
    t_cop();
    t_jumps();
    t_slot();
    give_verdict();
  end

  // the whole sequence needs about 140 cycles; allow twenty times that
  initial begin
    #(50 * 3000);
    fail_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
